// >>> sifd_decoder.sv
// top: instruction field decoder with register port and mode-change hold
// What this block does
// - classify 36-bit words into three layouts
// - storage layout function, type, register, base, displacement
// - register layout four registers, three selectors
// - vector layout files, length, mask control
// - type field integer/float, odd means double
// - length selector picks one loop count
// - zero count is valid, no elements
// - elements processed from zero for count
// - mask bits 64 single, 32 double
// - mask control 0 or 2 enables all
// - mask control 1 enables zero bits
// - mask control 3 enables one bits
// - disabled elements: no result, no fault
// - base 0 uses displacement as offset
// - base 15 appends five bits to pointer
// - offset under 4K local, else main storage
// - bases 1-14 add displacement to register
// - register reference needs both translations ok
// - mode-changing instruction waits for quiescence
// - float operands normalized except for add
// - reserved type raises undefined-instruction
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sifd_decoder
    import sifd_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          clkEn,
    input  wire logic          syncRst,
    input  wire sifd_instr_t   instrIn,
    output logic               instrReady,
    input  wire logic          quiescent,
    output logic [3:0]         gRegSel,
    input  wire logic [35:0]   gRegData,
    output sifd_decoded_t      decodedOut,
    input  wire logic          xlateTargetOk,
    input  wire logic          xlateBaseOk,
    output logic               storRefValid,
    output logic               storRefFault,
    input  wire logic [7:0]    regAddr,
    input  wire logic [31:0]   regWrData,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output logic [31:0]        regRdData
);

    logic [35:0]        word;
    logic [1:0]         fClass;
    sifd_layout_t       layout;
    logic [2:0]         dataType;
    logic [3:0]         baseSel;
    logic [15:0]        disp;
    logic [15:0]        localOffset;
    logic               directBase;
    logic               offsetLocal;
    logic [35:0]        mainAddr;
    logic [35:0]        regAddrSum;
    logic [1:0]         lenSel;
    logic [1:0]         maskCtl;
    logic [30:0]        loopEntry;
    logic [6:0]         selCount;
    logic               isDouble;
    logic [63:0]        wrEn;
    logic               looseBits;
    logic               holdNeeded;
    logic               accept;
    sifd_state_t        state_r;
    sifd_state_t        state_nxt;
    sifd_decoded_t      dec_r;
    sifd_decoded_t      dec_nxt;

    logic [LOOP_AW-1:0] loopPtr_r;
    logic [PTR_W-1:0]   ptr_r;
    logic [35:0]        segBase_r;
    logic [63:0]        mask_r;
    logic [30:0]        loopMem [LOOP_N];
    logic [31:0]        rdData_r;
    logic [31:0]        rdMux;
    logic               isLoopAddr;

    // field extraction
    assign word     = instrIn.word;
    assign fClass   = word[FUNC_HI -: 2];
    assign dataType = word[TYPE_HI:TYPE_LO];
    assign baseSel  = word[R2_HI:R2_LO];
    assign disp     = word[DISP_HI:DISP_LO];
    assign lenSel   = word[LEN_HI:LEN_LO];
    assign maskCtl  = word[S3_HI:S3_LO];
    assign isDouble = dataType[0];

    // layout by function class
    assign layout = (fClass == CLASS_VECTOR) ? LAYOUT_VECTOR :
                    (fClass == CLASS_REGOP)  ? LAYOUT_REGISTER :
                    LAYOUT_STORAGE;

    // positions that must read zero in each layout
    assign looseBits = (layout == LAYOUT_STORAGE)  ? (lenSel != 2'h0) :
                       (layout == LAYOUT_REGISTER) ? (lenSel != 2'h0) :
                       (word[R4_HI:R4_LO] != 4'h0);

    // local storage offset forming
    assign directBase  = (baseSel == BASE_DIRECT);
    assign localOffset = directBase ? disp :
                         {ptr_r, disp[4:0]};
    assign offsetLocal = (localOffset < LOCAL_LIMIT);
    assign mainAddr    = segBase_r + {20'h0_0000, localOffset};
    assign gRegSel     = baseSel;
    assign regAddrSum  = gRegData + {20'h0_0000, disp};

    // element count from the current loop entry
    assign loopEntry = loopMem[loopPtr_r];
    assign selCount  = loopEntry[lenSel*8 +: CNT_W];

    // per-element write enables
    for (genvar i = 0; i < ELEM_MAX; i++) begin : g_elem
        logic inRange;
        logic maskOk;
        assign inRange = (7'(i) < selCount)
                         && (i < ELEM_DBL || !isDouble);
        assign maskOk  = (maskCtl == 2'h0) || (maskCtl == 2'h2)
                         || (maskCtl == 2'h1 && !mask_r[i])
                         || (maskCtl == 2'h3 && mask_r[i]);
        assign wrEn[i] = inRange && maskOk;
    end

    // mode-change hold
    assign holdNeeded = instrIn.valid && instrIn.modeChange && !quiescent;
    assign instrReady = !holdNeeded;
    assign accept     = instrIn.valid && instrReady;
    assign state_nxt  = holdNeeded ? ST_HOLD : ST_RUN;

    // next decoded record
    always_comb begin
        dec_nxt                = '0;
        dec_nxt.valid          = accept;
        dec_nxt.layout         = layout;
        dec_nxt.func           = word[FUNC_HI:FUNC_LO];
        dec_nxt.dataType       = dataType;
        dec_nxt.isDouble       = isDouble;
        dec_nxt.isFloat        = dataType[1] && !dataType[2];
        dec_nxt.undefInstr     = dataType[2];
        dec_nxt.fpNormRequired = dec_nxt.isFloat &&
                                 (dec_nxt.func != FUNC_FADD);
        dec_nxt.fpAddNormalize = dec_nxt.isFloat &&
                                 (dec_nxt.func == FUNC_FADD);
        dec_nxt.looseBitsSet   = looseBits;
        dec_nxt.reg1           = word[R1_HI:R1_LO];
        dec_nxt.reg2           = baseSel;
        unique case (layout)
            LAYOUT_STORAGE: begin
                dec_nxt.isRegBased = !directBase && (baseSel != BASE_POINTER);
                dec_nxt.isLocal    = !dec_nxt.isRegBased && offsetLocal;
                dec_nxt.baseAddr   = gRegData;
                if (dec_nxt.isRegBased) begin
                    dec_nxt.storAddr = regAddrSum;
                end else if (offsetLocal) begin
                    dec_nxt.storAddr = {20'h0_0000, localOffset};
                end else begin
                    dec_nxt.storAddr = mainAddr;
                end
            end
            LAYOUT_REGISTER: begin
                dec_nxt.reg3 = word[R3_HI:R3_LO];
                dec_nxt.reg4 = word[R4_HI:R4_LO];
                dec_nxt.sel1 = word[S1_HI:S1_LO];
                dec_nxt.sel2 = word[S2_HI:S2_LO];
                dec_nxt.sel3 = word[S3_HI:S3_LO];
            end
            LAYOUT_VECTOR: begin
                dec_nxt.reg3      = word[R3_HI:R3_LO];
                dec_nxt.sel1      = word[S1_HI:S1_LO];
                dec_nxt.sel2      = word[S2_HI:S2_LO];
                dec_nxt.lengthSel = lenSel;
                dec_nxt.maskCtl   = maskCtl;
                dec_nxt.elemCount = selCount;
                dec_nxt.elemWrEn  = dec_nxt.undefInstr ? 64'h0 : wrEn;
            end
            default: begin
                dec_nxt.valid = 1'b0;
            end
        endcase
    end

    // decoded record and hold state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dec_r   <= '0;
            state_r <= ST_RUN;
        end else if (clkEn) begin
            if (syncRst) begin
                dec_r.valid <= 1'b0;
                state_r     <= ST_RUN;
            end else begin
                dec_r   <= dec_nxt;
                state_r <= state_nxt;
            end
        end
    end

    assign decodedOut   = dec_r;
    assign storRefValid = dec_r.valid && dec_r.isRegBased &&
                          xlateTargetOk && xlateBaseOk;
    assign storRefFault = dec_r.valid && dec_r.isRegBased &&
                          !(xlateTargetOk && xlateBaseOk);

    // register port
    assign isLoopAddr = (regAddr[7:5] == ADDR_LOOP[7:5]) && (regAddr[1:0] == 2'h0);

    always_comb begin
        rdMux = RST_WORD;
        if (isLoopAddr) begin
            rdMux = {1'b0, loopMem[regAddr[4:2]]};
        end else begin
            unique case (regAddr)
                ADDR_CTRL:   rdMux = {29'h0, loopPtr_r};
                ADDR_PTR:    rdMux = {21'h0, ptr_r};
                ADDR_SEGLO:  rdMux = segBase_r[31:0];
                ADDR_SEGHI:  rdMux = {28'h0, segBase_r[35:32]};
                ADDR_MASKLO: rdMux = mask_r[31:0];
                ADDR_MASKHI: rdMux = mask_r[63:32];
                ADDR_STATUS: rdMux = {26'h0, dec_r.undefInstr, dec_r.valid,
                                      dec_r.layout == LAYOUT_VECTOR,
                                      quiescent, state_r == ST_HOLD, 1'b0};
                default:     rdMux = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loopPtr_r <= '0;
            ptr_r     <= '0;
            segBase_r <= '0;
            mask_r    <= '0;
            rdData_r  <= RST_WORD;
        end else if (clkEn) begin
            rdData_r <= regRd ? rdMux : RST_WORD;
            if (regWr) begin
                unique case (regAddr)
                    ADDR_CTRL:   loopPtr_r         <= regWrData[LOOP_AW-1:0];
                    ADDR_PTR:    ptr_r             <= regWrData[PTR_W-1:0];
                    ADDR_SEGLO:  segBase_r[31:0]   <= regWrData;
                    ADDR_SEGHI:  segBase_r[35:32]  <= regWrData[3:0];
                    ADDR_MASKLO: mask_r[31:0]      <= regWrData;
                    ADDR_MASKHI: mask_r[63:32]     <= regWrData;
                    default:     ;
                endcase
            end
        end
    end

    // loop count entries
    for (genvar e = 0; e < LOOP_N; e++) begin : g_loop
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                loopMem[e] <= '0;
            end else if (clkEn && regWr && isLoopAddr && regAddr[4:2] == 3'(e)) begin
                loopMem[e] <= regWrData[30:0];
            end
        end
    end

    assign regRdData = rdData_r;

endmodule
`default_nettype wire

// >>> sifd_pkg.sv
// package: field layout, register map and types of the instruction field decoder
package sifd_pkg;

    localparam int WORD_W     = 36;
    localparam int FUNC_HI    = 35;
    localparam int FUNC_LO    = 29;
    localparam int TYPE_HI    = 28;
    localparam int TYPE_LO    = 26;
    localparam int R1_HI      = 25;
    localparam int R1_LO      = 22;
    localparam int R2_HI      = 21;
    localparam int R2_LO      = 18;
    localparam int LEN_HI     = 17;
    localparam int LEN_LO     = 16;
    localparam int R3_HI      = 15;
    localparam int R3_LO      = 12;
    localparam int R4_HI      = 11;
    localparam int R4_LO      = 8;
    localparam int S1_HI      = 7;
    localparam int S1_LO      = 5;
    localparam int S2_HI      = 4;
    localparam int S2_LO      = 2;
    localparam int S3_HI      = 1;
    localparam int S3_LO      = 0;
    localparam int DISP_HI    = 15;
    localparam int DISP_LO    = 0;
    localparam int PTR_W      = 11;
    localparam int ELEM_MAX   = 64;
    localparam int ELEM_DBL   = 32;
    localparam int CNT_W      = 7;
    localparam int LOOP_N     = 8;
    localparam int LOOP_AW    = 3;

    localparam logic [1:0]  CLASS_VECTOR = 2'h3;
    localparam logic [1:0]  CLASS_REGOP  = 2'h2;
    localparam logic [6:0]  FUNC_FADD    = 7'h01;
    localparam logic [3:0]  BASE_DIRECT  = 4'h0;
    localparam logic [3:0]  BASE_POINTER = 4'hF;
    localparam logic [15:0] LOCAL_LIMIT  = 16'h1000;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PTR    = 8'h04;
    localparam logic [7:0] ADDR_SEGLO  = 8'h08;
    localparam logic [7:0] ADDR_SEGHI  = 8'h0C;
    localparam logic [7:0] ADDR_MASKLO = 8'h10;
    localparam logic [7:0] ADDR_MASKHI = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_LOOP   = 8'h20;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    typedef enum logic [2:0] {
        LAYOUT_STORAGE  = 3'b001,
        LAYOUT_REGISTER = 3'b010,
        LAYOUT_VECTOR   = 3'b100
    } sifd_layout_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b10
    } sifd_state_t;

    typedef struct packed {
        logic        valid;
        logic [35:0] word;
        logic        modeChange;
    } sifd_instr_t;

    typedef struct packed {
        logic               valid;
        sifd_layout_t       layout;
        logic [6:0]         func;
        logic [2:0]         dataType;
        logic               isDouble;
        logic               isFloat;
        logic               undefInstr;
        logic               fpNormRequired;
        logic               fpAddNormalize;
        logic               looseBitsSet;
        logic [3:0]         reg1;
        logic [3:0]         reg2;
        logic [3:0]         reg3;
        logic [3:0]         reg4;
        logic [2:0]         sel1;
        logic [2:0]         sel2;
        logic [1:0]         sel3;
        logic [1:0]         lengthSel;
        logic [1:0]         maskCtl;
        logic [6:0]         elemCount;
        logic [63:0]        elemWrEn;
        logic               isLocal;
        logic               isRegBased;
        logic [35:0]        storAddr;
        logic [35:0]        baseAddr;
    } sifd_decoded_t;

endpackage

// >>> sifd_decoder_chk.sv
// checker: port-level properties of the instruction field decoder
`timescale 1ns/1ps
`default_nettype none
module sifd_decoder_chk
    import sifd_pkg::*;
(
    input wire logic          clk,
    input wire logic          nrst,
    input wire logic          clkEn,
    input wire logic          syncRst,
    input wire sifd_instr_t   instrIn,
    input wire logic          instrReady,
    input wire logic          quiescent,
    input wire logic [35:0]   gRegData,
    input wire sifd_decoded_t decodedOut,
    input wire logic          xlateTargetOk,
    input wire logic          xlateBaseOk,
    input wire logic          storRefValid,
    input wire logic          storRefFault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ready_hold_a: assert property (instrReady == !(instrIn.valid && instrIn.modeChange && !quiescent))
        else $error("ready wrong for mode-change hold");
    accept_valid_a: assert property (clkEn && !syncRst && instrIn.valid && instrReady |=>
        decodedOut.valid) else $error("accepted word gave no valid");
    refuse_quiet_a: assert property (clkEn && !(instrIn.valid && instrReady) |=>
        !decodedOut.valid) else $error("valid without accepted word");
    func_field_a: assert property ($past(clkEn) && decodedOut.valid |->
        decodedOut.func == $past(instrIn.word[35:29])
        && decodedOut.dataType == $past(instrIn.word[28:26])) else $error("function or type wrong");
    type_decode_a: assert property (decodedOut.valid |-> decodedOut.isDouble ==
        decodedOut.dataType[0] && decodedOut.undefInstr == decodedOut.dataType[2])
        else $error("type decode wrong");
    undef_noen_a: assert property (decodedOut.valid && decodedOut.undefInstr |->
        decodedOut.elemWrEn == '0 && !decodedOut.isFloat) else $error("reserved type enabled");
    zero_count_a: assert property (decodedOut.valid && decodedOut.layout == LAYOUT_VECTOR
        && decodedOut.elemCount == 7'h00 |-> decodedOut.elemWrEn == '0)
        else $error("zero count wrote elements");
    dir_local_a: assert property ($past(clkEn) && decodedOut.valid
        && decodedOut.layout == LAYOUT_STORAGE && $past(instrIn.word[21:18]) == 4'h0
        |-> decodedOut.isLocal == ($past(instrIn.word[15:0]) < LOCAL_LIMIT))
        else $error("local choice wrong");
    reg_addr_a: assert property ($past(clkEn) && decodedOut.valid && decodedOut.isRegBased
        |-> !decodedOut.isLocal && decodedOut.storAddr ==
        $past(gRegData) + {20'h00000, $past(instrIn.word[15:0])}) else $error("sum wrong");
    xlate_ok_a: assert property (decodedOut.valid && decodedOut.isRegBased |->
        storRefValid == (xlateTargetOk && xlateBaseOk)) else $error("reference validity wrong");
    fault_flag_a: assert property (storRefFault == (decodedOut.valid && decodedOut.isRegBased
        && !(xlateTargetOk && xlateBaseOk))) else $error("reference fault wrong");
    fp_norm_a: assert property (decodedOut.valid && decodedOut.isFloat |->
        decodedOut.fpNormRequired == (decodedOut.func != FUNC_FADD)
        && decodedOut.fpAddNormalize == (decodedOut.func == FUNC_FADD)) else $error("norm flags wrong");

    cover property (decodedOut.valid && decodedOut.layout == LAYOUT_VECTOR);
    cover property (instrIn.valid && !instrReady);
    cover property (decodedOut.valid && decodedOut.isRegBased);
    cover property (syncRst && instrIn.valid && instrReady);
endmodule
bind sifd_decoder sifd_decoder_chk u_chk (.clk, .nrst, .clkEn, .syncRst, .instrIn, .instrReady,
    .quiescent, .gRegData, .decodedOut, .xlateTargetOk, .xlateBaseOk, .storRefValid,
    .storRefFault);
`default_nettype wire

// >>> sifd_exec_model.sv
// model: execution side giving quiescence, register contents, translation results
`timescale 1ns/1ps
`default_nettype none
module sifd_exec_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  busyLoad,
    input  wire logic        denyXlate,
    input  wire logic [3:0]  gRegSel,
    output logic             quiescent,
    output logic [35:0]      gRegData,
    output logic             xlateTargetOk,
    output logic             xlateBaseOk
);
    logic [4:0] busyCnt_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) busyCnt_r <= 5'h00;
        else if (busyLoad != 5'h00) busyCnt_r <= busyLoad;
        else if (busyCnt_r != 5'h00) busyCnt_r <= busyCnt_r - 5'h01;
    end
    assign quiescent     = (busyCnt_r == 5'h00);
    assign gRegData      = {gRegSel, 32'h0000_8000};
    assign xlateTargetOk = !denyXlate;
    assign xlateBaseOk   = 1'b1;
endmodule
`default_nettype wire

// >>> sifd_decoder_tb.sv
// testbench: decoder driven through issue and register tasks
`timescale 1ns/1ps
`default_nettype none
module sifd_decoder_tb;
    import sifd_pkg::*;
    logic          clk, nrst, clkEn, syncRst, quiescent, xlateTargetOk, xlateBaseOk;
    logic          instrReady, storRefValid, storRefFault, regWr, regRd, denyXlate;
    logic [3:0]    gRegSel;
    logic [4:0]    busyLoad;
    logic [35:0]   gRegData, w, sa[4];
    logic [7:0]    regAddr;
    logic [31:0]   regWrData, regRdData, r;
    logic [63:0]   e;
    logic [6:0]    n, cnts[4];
    logic [15:0]   da[4];
    logic [3:0]    ba[4];
    sifd_instr_t   instrIn;
    sifd_decoded_t dOut;
    int            mismatches, n_compared, waited;

    sifd_decoder u_dut (.clk, .nrst, .clkEn, .syncRst, .instrIn, .instrReady, .quiescent,
        .gRegSel, .gRegData, .decodedOut(dOut), .xlateTargetOk, .xlateBaseOk, .storRefValid,
        .storRefFault, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
    sifd_exec_model u_model (.clk, .nrst, .busyLoad, .denyXlate, .gRegSel, .quiescent,
        .gRegData, .xlateTargetOk, .xlateBaseOk);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask
    task automatic issue(input logic [35:0] iw, input logic m);
        @(posedge clk);
        instrIn <= '{1'b1, iw, m};
        waited = 0;
        do begin
            @(posedge clk);
            waited++;
        end while (!instrReady && waited < 100);
        instrIn.valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        {nrst, clkEn, syncRst, regWr, regRd, denyXlate} = 6'b010000;
        {regAddr, regWrData, busyLoad} = '0;
        instrIn = '0;
        cnts = '{7'h21, 7'h05, 7'h00, 7'h40};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_CTRL, r);
        chk(r, 0);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, r);
        chk(r, 0);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_LOOP, 32'h0303_0303);
        wr(ADDR_LOOP + 8'h08, 32'h4000_0521);
        wr(ADDR_MASKLO, 32'hF0F0_F00F);
        wr(ADDR_MASKHI, 32'h8000_00FF);
        rd(ADDR_LOOP + 8'h08, r);
        chk(r, 32'h4000_0521);
        for (int c = 0; c < 4; c++) begin
            for (int l = 0; l < 4; l++) begin
                for (int t = 0; t < 2; t++) begin
                    w = {7'h60, 3'(t), 8'h12, 2'(l), 8'h30, 6'o11, 2'(c)};
                    issue(w, 1'b0);
                    n = (t == 1 && cnts[l] > 7'h20) ? 7'h20 : cnts[l];
                    e = (n == 7'h40) ? '1 : (64'h1 << n) - 64'h1;
                    if (c == 1) e = e & ~64'h8000_00FF_F0F0_F00F;
                    if (c == 3) e = e & 64'h8000_00FF_F0F0_F00F;
                    chk(dOut.elemWrEn, e);
                    chk({dOut.layout, dOut.elemCount, dOut.lengthSel, dOut.maskCtl,
                        dOut.looseBitsSet},
                        {LAYOUT_VECTOR, cnts[l], 2'(l), 2'(c), 1'b0});
                end
            end
        end
        for (int t = 0; t < 8; t++) begin
            issue({7'h40, 3'(t), 8'h56, 2'b00, 8'h78, 8'h4B}, 1'b0);
            chk({dOut.layout, dOut.isDouble, dOut.isFloat, dOut.undefInstr, dOut.reg1,
                dOut.reg2, dOut.reg3, dOut.reg4, dOut.sel1, dOut.sel2, dOut.sel3,
                dOut.fpNormRequired, dOut.looseBitsSet},
                {LAYOUT_REGISTER, 1'(t % 2), t == 2 || t == 3, t > 3, 16'h5678, 8'h4B,
                t == 2 || t == 3, 1'b0});
        end
        wr(ADDR_SEGLO, 32'h0010_0000);
        wr(ADDR_SEGHI, 32'h2);
        wr(ADDR_PTR, 32'h080);
        rd(ADDR_PTR, r);
        chk(r, 32'h080);
        ba = '{4'h0, 4'h0, 4'hF, 4'h5};
        da = '{16'h0FFF, 16'h1000, 16'hFFE3, 16'hFFFF};
        sa = '{36'h0_0000_0FFF, 36'h2_0010_1000, 36'h2_0010_1003, 36'h5_0001_7FFF};
        for (int i = 0; i < 4; i++) begin
            issue({7'h10, 3'h0, 4'h9, ba[i], 2'b00, da[i]}, 1'b0);
            chk({dOut.isLocal, dOut.isRegBased, dOut.storAddr},
                {i == 0, i == 3, sa[i]});
            if (i == 3) chk({storRefValid, storRefFault, dOut.baseAddr},
                {2'b10, 36'h5_0000_8000});
        end
        denyXlate <= 1'b1;
        issue({7'h10, 3'h0, 4'h9, 4'h5, 2'b00, 16'h0004}, 1'b0);
        chk(storRefValid, 0);
        chk(storRefFault, 1);
        denyXlate <= 1'b0;
        issue({FUNC_FADD, 3'h2, 4'h1, 4'h0, 2'b01, 16'h0010}, 1'b0);
        chk({dOut.isFloat, dOut.fpNormRequired, dOut.fpAddNormalize,
            dOut.looseBitsSet}, 4'hB);
        busyLoad <= 5'd12;
        @(posedge clk);
        busyLoad <= 5'd0;
        issue(36'h0_0000_0001, 1'b0);
        chk(waited, 1);
        issue(36'h0_0000_0002, 1'b1);
        chk(waited > 5 && waited < 14, 1);
        chk(dOut.valid, 1);
        @(negedge clk);
        chk(dOut.valid, 0);
        @(posedge clk);
        syncRst <= 1'b1;
        issue(36'h0_0000_0003, 1'b0);
        chk(dOut.valid, 0);
        @(posedge clk);
        syncRst <= 1'b0;
        instrIn <= '{1'b1, 36'h0_0000_0005, 1'b0};
        @(posedge clk);
        instrIn.valid <= 1'b0;
        clkEn <= 1'b0;
        repeat (2) @(negedge clk);
        chk(dOut.valid, 1);
        @(posedge clk);
        clkEn <= 1'b1;
        repeat (2) @(negedge clk);
        chk(dOut.valid, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
